// ==== sfp_pkg.sv ====
package sfp_pkg;

	// ==========================================
	// opcodes
	localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
	localparam logic [7:0] OP_STATUS_READ   = 8'h05;
	localparam logic [7:0] OP_SLEEP         = 8'hb9;
	localparam logic [7:0] OP_WAKE_ID       = 8'hab;
	localparam logic [7:0] OP_ID4           = 8'h9f;
	localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
	localparam logic [7:0] OP_SECT_ERASE_A  = 8'h20;
	localparam logic [7:0] OP_SECT_ERASE_B  = 8'hd7;
	localparam logic [7:0] OP_BLOCK_ERASE   = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A  = 8'h60;
	localparam logic [7:0] OP_CHIP_ERASE_B  = 8'hc7;

	// ==========================================
	// framing counts, in whole bytes, and the last bit index of a byte
	localparam logic [7:0] BYTES_SINGLE     = 8'h01;
	localparam logic [7:0] BYTES_STATUS_WR  = 8'h02;
	localparam logic [7:0] BYTES_ADDR_CMD   = 8'h04;
	localparam logic [7:0] BYTES_PROG_MIN   = 8'h05;
	localparam logic [7:0] BYTES_MAX        = 8'hff;
	localparam logic [2:0] BIT_LAST         = 3'h7;

	// ==========================================
	// status byte layout
	localparam int ST_BUSY   = 0;
	localparam int ST_WEL    = 1;
	localparam int ST_BP_LO  = 2;
	localparam int ST_TB     = 5;
	localparam int ST_LOCK   = 7;

	// ==========================================
	// reset values
	localparam logic [2:0] RST_PROT_LEVEL = 3'h0;
	localparam logic       RST_FROM_BOT   = 1'b0;
	localparam logic       RST_LOCK       = 1'b0;

	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TMR_W         = 24;

	// ==========================================
	// types
	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'h0,
		PWR_ENTER  = 2'h1,
		PWR_SLEEP  = 2'h3,
		PWR_WAKE   = 2'h2
	} sfp_pwr_t;

	typedef struct packed {
		logic cs_b;
		logic sck;
		logic si;
		logic wp_b;
	} sfp_pins_t;

	typedef struct packed {
		logic       lock;
		logic       from_bottom;
		logic [2:0] prot_level;
	} sfp_prot_t;

endpackage

// ==== sfp_sync.sv ====
`timescale 1ns/10ps
module sfp_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// pins
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sfp_sync_st_t;

	sfp_sync_st_t st_q;
	sfp_sync_st_t st_d;

	// first stage feeds only the second
	always_comb begin
		st_d    = st_q;
		st_d.s1 = din;
		st_d.s2 = st_q.s1;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.s2;

endmodule

// ==== sfp_timer.sv ====
`timescale 1ns/10ps
module sfp_timer
	import sfp_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_b,
	// control
	input  wire logic             start,
	input  wire logic [TMR_W-1:0] load,
	output logic                  done,
	output logic                  running
);

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             run;
		logic             done;
	} sfp_tmr_st_t;

	sfp_tmr_st_t st_q;
	sfp_tmr_st_t st_d;

	always_comb begin
		st_d      = st_q;
		st_d.done = 1'b0;
		if (start) begin
			st_d.cnt = load;
			st_d.run = 1'b1;
		end else if (st_q.run) begin
			if (st_q.cnt <= TMR_W'(1)) begin
				st_d.run  = 1'b0;
				st_d.done = 1'b1;
				st_d.cnt  = '0;
			end else begin
				st_d.cnt = st_q.cnt - TMR_W'(1);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign done    = st_q.done;
	assign running = st_q.run;

endmodule

// ==== sfp_flash_cmd.sv ====
// Function
// - write-disable opcode clears the write-enable latch.
// - write-disable framed by chip select; acts on the select rising edge.
// - status write changes only protect level, bottom select and lock bits.
// - accepted status write runs self-timed with busy set; host polls or waits.
// - status write changes no protect or lock bits while write-protect low and lock bit set; it still clears write-enable.
// - with write-protect low, lock bit may only go from zero to one.
// - with write-protect high, lock and all protect bits may change.
// - lock checked at select rise; one write may lock and change bits.
// - sleep opcode framed by chip select; sleep starts after the rising edge.
// - sleep opcode ignored while a self-timed operation runs.
// - in sleep every opcode except release/identify is ignored.
// - lowest power reached only after the sleep entry delay.
// - framed release opcode returns to standby; host waits the wake delay.
// - single-byte identify: opcode, 24 dummy bits, then id byte repeated.
// - four-byte identify order: device id, type, capacity, reserved.
// - four-byte code repeats; output stops whenever chip select rises.
// - write-type command rejected unless select rises on a byte boundary.
// - page program with a partial data byte is not recognised.
// - status write longer than one data byte is rejected.
// - power-up reset puts command logic and latches in idle.
// - write-enable sets the latch unless busy; a status write clears it at the select rise that accepts it.
// - status read streams status until select rises, even while busy.
`timescale 1ns/10ps
module sfp_flash_cmd
	import sfp_pkg::*;
#(
	parameter int         STATUS_WRITE_NS = 10000,
	parameter int         WRITE_OP_NS     = 200000,
	parameter int         SLEEP_ENTRY_NS  = 3000,
	parameter int         WAKE_NS         = 3000,
	// identification values are arbitrary
	parameter logic [7:0] ID_BYTE         = 8'h7c,
	parameter logic [7:0] ID_DEVICE       = 8'hc1,
	parameter logic [7:0] ID_MEM_TYPE     = 8'h27,
	parameter logic [7:0] ID_CAPACITY     = 8'h35,
	parameter logic [7:0] ID_RESERVED     = 8'h4e
) (
	// clock and reset
	input  wire logic       CORE_CLK,
	input  wire logic       RST_B,
	// serial pins
	input  wire logic       SPI_CS_B,
	input  wire logic       SPI_SCK,
	input  wire logic       SPI_SI,
	input  wire logic       SPI_WP_B,
	output logic            SPI_SO,
	output logic            SPI_SO_OE,
	// status
	output logic            BUSY,
	output logic            WRITE_EN,
	output logic [2:0]      PROTECT_LEVEL,
	output logic            PROTECT_FROM_BOTTOM,
	output logic            STATUS_LOCK,
	output logic            DEEP_SLEEP,
	// array operation launch
	output logic            WRITE_OP_START,
	output logic [7:0]      WRITE_OP_CODE
);

	// ==========================================
	// timing counts
	localparam logic [TMR_W-1:0] STATUS_WRITE_CYC =
		TMR_W'((STATUS_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] WRITE_OP_CYC =
		TMR_W'((WRITE_OP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] SLEEP_ENTRY_CYC =
		TMR_W'((SLEEP_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] WAKE_CYC =
		TMR_W'((WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ==========================================
	// state
	typedef struct packed {
		logic       sck_prev;
		logic       cs_prev;
		logic [2:0] bit_cnt;
		logic [7:0] byte_cnt;
		logic [7:0] rx;
		logic [7:0] opcode;
		logic [7:0] data1;
		logic [7:0] tx;
		logic       so;
		logic       so_oe;
		logic       wel;
		logic       busy;
		sfp_prot_t  prot;
		sfp_pwr_t   pwr;
		logic       low_power;
		logic [7:0] wop_code;
		logic       wop_start;
	} sfp_core_st_t;

	sfp_core_st_t st_q;
	sfp_core_st_t st_d;

	sfp_pins_t  pin_raw;
	sfp_pins_t  pin_s;
	logic       sck_rise;
	logic       sck_fall;
	logic       cs_rise;
	logic       selected;
	logic       on_boundary;
	logic       op_known;
	logic       op_write_type;
	logic       op_frame_ok;
	logic [7:0] status_byte;
	logic [7:0] out_byte;
	logic       out_phase;
	logic       busy_start;
	logic [TMR_W-1:0] busy_load;
	logic       busy_done;
	logic       pwr_start;
	logic [TMR_W-1:0] pwr_load;
	logic       pwr_done;
	logic [7:0] rx_next;

	// ==========================================
	// pin sampling
	assign pin_raw = '{cs_b: SPI_CS_B, sck: SPI_SCK, si: SPI_SI, wp_b: SPI_WP_B};

	sfp_sync #(
		.W ($bits(sfp_pins_t))
	) u_sync (
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.din   (pin_raw),
		.dout  (pin_s)
	);

	assign sck_rise = pin_s.sck & ~st_q.sck_prev;
	assign sck_fall = ~pin_s.sck & st_q.sck_prev;
	assign cs_rise  = pin_s.cs_b & ~st_q.cs_prev;
	assign selected = ~pin_s.cs_b;
	assign rx_next  = {st_q.rx[6:0], pin_s.si};

	// ==========================================
	// timers
	sfp_timer u_busy_tmr (
		.clk     (CORE_CLK),
		.rst_b   (RST_B),
		.start   (busy_start),
		.load    (busy_load),
		.done    (busy_done),
		.running ()
	);

	sfp_timer u_pwr_tmr (
		.clk     (CORE_CLK),
		.rst_b   (RST_B),
		.start   (pwr_start),
		.load    (pwr_load),
		.done    (pwr_done),
		.running ()
	);

	// ==========================================
	// decode helpers
	always_comb begin
		status_byte           = '0;
		status_byte[ST_BUSY]  = st_q.busy;
		status_byte[ST_WEL]   = st_q.wel;
		status_byte[ST_BP_LO +: 3] = st_q.prot.prot_level;
		status_byte[ST_TB]    = st_q.prot.from_bottom;
		status_byte[ST_LOCK]  = st_q.prot.lock;
	end

	assign on_boundary = (st_q.bit_cnt == 3'h0);

	always_comb begin
		op_write_type = 1'b0;
		op_frame_ok   = 1'b0;
		case (st_q.opcode)
			OP_PAGE_PROG: begin
				op_write_type = 1'b1;
				op_frame_ok   = (st_q.byte_cnt >= BYTES_PROG_MIN);
			end
			OP_SECT_ERASE_A, OP_SECT_ERASE_B, OP_BLOCK_ERASE: begin
				op_write_type = 1'b1;
				op_frame_ok   = (st_q.byte_cnt == BYTES_ADDR_CMD);
			end
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: begin
				op_write_type = 1'b1;
				op_frame_ok   = (st_q.byte_cnt == BYTES_SINGLE);
			end
			default: begin
				op_write_type = 1'b0;
				op_frame_ok   = 1'b0;
			end
		endcase
	end

	assign op_known = (st_q.byte_cnt != 8'h00) &&
		((st_q.pwr == PWR_ACTIVE) || (st_q.opcode == OP_WAKE_ID));

	// ==========================================
	// readout source
	always_comb begin
		out_byte  = '0;
		out_phase = 1'b0;
		if (op_known) begin
			case (st_q.opcode)
				OP_STATUS_READ: begin
					out_phase = 1'b1;
					out_byte  = status_byte;
				end
				OP_WAKE_ID: begin
					out_phase = (st_q.byte_cnt >= BYTES_ADDR_CMD);
					out_byte  = ID_BYTE;
				end
				OP_ID4: begin
					out_phase = 1'b1;
					case (2'(st_q.byte_cnt - 8'h01))
						2'h0:    out_byte = ID_DEVICE;
						2'h1:    out_byte = ID_MEM_TYPE;
						2'h2:    out_byte = ID_CAPACITY;
						default: out_byte = ID_RESERVED;
					endcase
				end
				default: begin
					out_phase = 1'b0;
					out_byte  = '0;
				end
			endcase
		end
	end

	// ==========================================
	// main update
	always_comb begin
		st_d           = st_q;
		st_d.sck_prev  = pin_s.sck;
		st_d.cs_prev   = pin_s.cs_b;
		st_d.wop_start = 1'b0;
		busy_start     = 1'b0;
		busy_load      = STATUS_WRITE_CYC;
		pwr_start      = 1'b0;
		pwr_load       = SLEEP_ENTRY_CYC;

		if (busy_done) begin
			st_d.busy = 1'b0;
		end

		// shift in on rising clock
		if (selected && sck_rise) begin
			st_d.rx      = rx_next;
			st_d.bit_cnt = st_q.bit_cnt + 3'h1;
			if (st_q.bit_cnt == BIT_LAST) begin
				if (st_q.byte_cnt != BYTES_MAX) begin
					st_d.byte_cnt = st_q.byte_cnt + 8'h01;
				end
				if (st_q.byte_cnt == 8'h00) begin
					st_d.opcode = rx_next;
				end
				if (st_q.byte_cnt == BYTES_SINGLE) begin
					st_d.data1 = rx_next;
				end
			end
		end

		// shift out on falling clock
		if (selected && sck_fall) begin
			if (on_boundary && out_phase) begin
				st_d.so    = out_byte[7];
				st_d.tx    = {out_byte[6:0], 1'b0};
				st_d.so_oe = 1'b1;
			end else if (st_q.so_oe) begin
				st_d.so = st_q.tx[7];
				st_d.tx = {st_q.tx[6:0], 1'b0};
			end
		end

		if (!selected) begin
			st_d.so_oe    = 1'b0;
			st_d.so       = 1'b0;
			st_d.bit_cnt  = '0;
			st_d.byte_cnt = '0;
		end

		// commands act on the select rise
		if (cs_rise && op_known) begin
			case (st_q.opcode)
				OP_WRITE_ENABLE: begin
					if (on_boundary && st_q.byte_cnt == BYTES_SINGLE && !st_q.busy) begin
						st_d.wel = 1'b1;
					end
				end
				OP_WRITE_DISABLE: begin
					if (on_boundary && st_q.byte_cnt == BYTES_SINGLE) begin
						st_d.wel = 1'b0;
					end
				end
				OP_STATUS_WRITE: begin
					if (on_boundary && st_q.byte_cnt == BYTES_STATUS_WR &&
						st_q.wel && !st_q.busy) begin
						st_d.wel = 1'b0;
						if (pin_s.wp_b || !st_q.prot.lock) begin
							st_d.prot.prot_level  = st_q.data1[ST_BP_LO +: 3];
							st_d.prot.from_bottom = st_q.data1[ST_TB];
							st_d.prot.lock        = st_q.data1[ST_LOCK];
							st_d.busy  = 1'b1;
							busy_start = 1'b1;
							busy_load  = STATUS_WRITE_CYC;
						end
					end
				end
				OP_SLEEP: begin
					if (on_boundary && st_q.byte_cnt == BYTES_SINGLE &&
						!st_q.busy && st_q.pwr == PWR_ACTIVE) begin
						st_d.pwr  = PWR_ENTER;
						pwr_start = 1'b1;
						pwr_load  = SLEEP_ENTRY_CYC;
					end
				end
				OP_WAKE_ID: begin
					if (st_q.pwr == PWR_SLEEP || st_q.pwr == PWR_ENTER) begin
						st_d.pwr  = PWR_WAKE;
						pwr_start = 1'b1;
						pwr_load  = WAKE_CYC;
					end
				end
				default: begin
					if (op_write_type && op_frame_ok && on_boundary &&
						st_q.wel && !st_q.busy) begin
						st_d.wel       = 1'b0;
						st_d.wop_start = 1'b1;
						st_d.wop_code  = st_q.opcode;
						st_d.busy      = 1'b1;
						busy_start     = 1'b1;
						busy_load      = WRITE_OP_CYC;
					end
				end
			endcase
		end

		// power sequencing
		if (pwr_done) begin
			case (st_q.pwr)
				PWR_ENTER: st_d.pwr = PWR_SLEEP;
				PWR_WAKE:  st_d.pwr = PWR_ACTIVE;
				default:   st_d.pwr = st_q.pwr;
			endcase
		end
		st_d.low_power = (st_d.pwr == PWR_SLEEP);
	end

	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			st_q                  <= '0;
			st_q.sck_prev         <= 1'b0;
			st_q.cs_prev          <= 1'b1;
			st_q.prot.prot_level  <= RST_PROT_LEVEL;
			st_q.prot.from_bottom <= RST_FROM_BOT;
			st_q.prot.lock        <= RST_LOCK;
			st_q.pwr              <= PWR_ACTIVE;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// outputs
	assign SPI_SO              = st_q.so;
	assign SPI_SO_OE           = st_q.so_oe;
	assign BUSY                = st_q.busy;
	assign WRITE_EN            = st_q.wel;
	assign PROTECT_LEVEL       = st_q.prot.prot_level;
	assign PROTECT_FROM_BOTTOM = st_q.prot.from_bottom;
	assign STATUS_LOCK         = st_q.prot.lock;
	assign DEEP_SLEEP          = st_q.low_power;
	assign WRITE_OP_START      = st_q.wop_start;
	assign WRITE_OP_CODE       = st_q.wop_code;

endmodule

// ==== sfp_flash_cmd_monitor.sv ====
`timescale 1ns/10ps
// ======
// port checker
module sfp_flash_cmd_monitor (
	// clock and reset
	input wire logic       CORE_CLK,
	input wire logic       RST_B,
	// pins
	input wire logic       SPI_CS_B,
	input wire logic       SPI_WP_B,
	input wire logic       SPI_SO_OE,
	// status
	input wire logic       BUSY,
	input wire logic       WRITE_EN,
	input wire logic [2:0] PROTECT_LEVEL,
	input wire logic       PROTECT_FROM_BOTTOM,
	input wire logic       STATUS_LOCK,
	input wire logic       DEEP_SLEEP,
	input wire logic       WRITE_OP_START
);
	default clocking @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_B);

	oe_release_a: assert property (SPI_CS_B [*6] |-> !SPI_SO_OE)
		else $error("output enable held while deselected");
	oe_in_frame_a: assert property ($rose(SPI_SO_OE) |-> !SPI_CS_B)
		else $error("output enabled outside a frame");
	busy_launch_a: assert property ($rose(BUSY) |-> SPI_CS_B && $past(SPI_CS_B, 2))
		else $error("busy raised before select rise");
	// covers the longest timed operation in the bench setup
	busy_bound_a: assert property ($rose(BUSY) |-> ##[2:600] !BUSY)
		else $error("busy never cleared");
	wel_drop_a: assert property ($fell(WRITE_EN) |-> $past(SPI_CS_B, 2))
		else $error("write enable cleared inside a frame");
	lock_hold_a: assert property ($fell(STATUS_LOCK) |-> $past(SPI_WP_B, 3))
		else $error("lock cleared while write protect low");
	locked_freeze_a: assert property (STATUS_LOCK && !SPI_WP_B && !$past(SPI_WP_B, 6)
		|=> $stable({PROTECT_LEVEL, PROTECT_FROM_BOTTOM, STATUS_LOCK}))
		else $error("locked status changed");
	sleep_freeze_a: assert property (DEEP_SLEEP |=> $stable({WRITE_EN, PROTECT_LEVEL, STATUS_LOCK}))
		else $error("command acted on while asleep");
	sleep_idle_a: assert property (DEEP_SLEEP |-> !BUSY)
		else $error("asleep while busy");
	sleep_delay_a: assert property ($rose(DEEP_SLEEP) |-> SPI_CS_B && $past(SPI_CS_B, 6))
		else $error("sleep entered too early");
	op_pulse_a: assert property (WRITE_OP_START |=> !WRITE_OP_START && BUSY)
		else $error("launch pulse wrong");

	cover property ($rose(BUSY));
	cover property ($rose(DEEP_SLEEP));
	cover property ($rose(SPI_SO_OE));
endmodule

bind sfp_flash_cmd sfp_flash_cmd_monitor mon (
	.CORE_CLK            (CORE_CLK),
	.RST_B               (RST_B),
	.SPI_CS_B            (SPI_CS_B),
	.SPI_WP_B            (SPI_WP_B),
	.SPI_SO_OE           (SPI_SO_OE),
	.BUSY                (BUSY),
	.WRITE_EN            (WRITE_EN),
	.PROTECT_LEVEL       (PROTECT_LEVEL),
	.PROTECT_FROM_BOTTOM (PROTECT_FROM_BOTTOM),
	.STATUS_LOCK         (STATUS_LOCK),
	.DEEP_SLEEP          (DEEP_SLEEP),
	.WRITE_OP_START      (WRITE_OP_START)
);

// ==== sfp_host_model.sv ====
`timescale 1ns/10ps
// ======
// spi host, mode 0, link clock still between frames
module sfp_host_model (
	// link pins
	output logic      cs_b,
	output logic      sck,
	output logic      si,
	input  wire logic so
);
	logic [63:0] rx;

	initial begin
		cs_b = 1'b1;
		sck  = 1'b0;
		si   = 1'b0;
		rx   = 64'h0;
	end

	task automatic frame(input logic [7:0] op, input logic [63:0] dat, input int n);
		logic [71:0] tx;
		tx   = {op, dat << (72 - n)};
		cs_b = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = tx[71-i];
			#80 sck = 1'b1;
			// sample late: device output lags the falling edge
			#70 rx = {rx[62:0], so};
			#10 sck = 1'b0;
		end
		#80 cs_b = 1'b1;
		// released line shows the inverse, not the last bit
		si = ~si;
		#100;
	endtask
endmodule

// ==== tb_sfp_flash_cmd.sv ====
`timescale 1ns/10ps
module tb_sfp_flash_cmd
	import sfp_pkg::*;
;
	// arbitrary identification values
	localparam logic [7:0]  ID1 = 8'h5a;
	localparam logic [31:0] ID4 = 32'ha1b2c3d4;

	logic       clk;
	logic       rst_b;
	logic       wp_b;
	logic       cs_b;
	logic       sck;
	logic       si;
	logic       so;
	logic       oe;
	logic       busy;
	logic       wen;
	logic [2:0] lvl;
	logic       bot;
	logic       lock;
	logic       slp;
	logic       ops;
	logic [7:0] opc;
	int         error_cnt = 0;
	int         check_count = 0;
	int         op_pulses = 0;

	always #10 clk = ~clk;

	// launch pulse lasts one cycle, so count it as it passes
	always @(posedge clk) begin
		if (ops === 1'b1) begin
			op_pulses++;
		end
	end

	sfp_flash_cmd #(
		.STATUS_WRITE_NS (200),
		.WRITE_OP_NS     (10000),
		.SLEEP_ENTRY_NS  (100),
		.WAKE_NS         (100),
		.ID_BYTE         (ID1),
		.ID_DEVICE       (ID4[31:24]),
		.ID_MEM_TYPE     (ID4[23:16]),
		.ID_CAPACITY     (ID4[15:8]),
		.ID_RESERVED     (ID4[7:0])
	) uut (
		.CORE_CLK            (clk),
		.RST_B               (rst_b),
		.SPI_CS_B            (cs_b),
		.SPI_SCK             (sck),
		.SPI_SI              (si),
		.SPI_WP_B            (wp_b),
		.SPI_SO              (so),
		.SPI_SO_OE           (oe),
		.BUSY                (busy),
		.WRITE_EN            (wen),
		.PROTECT_LEVEL       (lvl),
		.PROTECT_FROM_BOTTOM (bot),
		.STATUS_LOCK         (lock),
		.DEEP_SLEEP          (slp),
		.WRITE_OP_START      (ops),
		.WRITE_OP_CODE       (opc)
	);

	sfp_host_model host (
		.cs_b (cs_b),
		.sck  (sck),
		.si   (si),
		.so   (so)
	);

	// ======
	// shared tasks
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic idle();
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 1000) begin
			@(posedge clk);
			k++;
		end
		chk("busy_end", 64'(busy), 64'h0);
	endtask

	task automatic status_read_cmd(input logic [7:0] e);
		host.frame(OP_STATUS_READ, 64'h0, 24);
		chk("status", 64'(host.rx[15:0]), 64'({e, e}));
	endtask

	task automatic wr(input logic [7:0] d);
		host.frame(OP_WRITE_ENABLE, 64'h0, 8);
		host.frame(OP_STATUS_WRITE, 64'(d), 16);
	endtask

	task automatic prot(input logic [4:0] e);
		idle();
		chk("protect", 64'({lock, bot, lvl}), 64'(e));
	endtask

	task automatic setwp(input logic v);
		@(posedge clk);
		wp_b <= v;
		cyc(4);
	endtask

	// ======
	// scenarios
	task automatic t_wel();
		host.frame(OP_WRITE_ENABLE, 64'h0, 8);
		chk("wel_set", 64'(wen), 64'h1);
		status_read_cmd(8'h02);
		host.frame(OP_WRITE_DISABLE, 64'h0, 9);
		chk("wel_partial", 64'(wen), 64'h1);
		host.frame(OP_WRITE_DISABLE, 64'h0, 8);
		chk("wel_clr", 64'(wen), 64'h0);
	endtask

	task automatic status_write_time();
		wr(8'hff);
		chk("busy_wel", 64'({busy, wen}), 64'h2);
		prot(5'h1f);
		status_read_cmd(8'hbc);
		setwp(1'b0);
		wr(8'h00);
		prot(5'h1f);
		setwp(1'b1);
		wr(8'h00);
		prot(5'h00);
		setwp(1'b0);
		wr(8'h94);
		prot(5'h15);
		wr(8'h14);
		prot(5'h15);
		setwp(1'b1);
		wr(8'h00);
		prot(5'h00);
	endtask

	task automatic t_reject();
		logic [7:0] op [5];
		int         nb [5];
		op = '{OP_STATUS_WRITE, OP_STATUS_WRITE, OP_STATUS_WRITE, OP_PAGE_PROG, OP_SECT_ERASE_A};
		nb = '{15, 17, 24, 44, 31};
		for (int i = 0; i < 5; i++) begin
			host.frame(OP_WRITE_ENABLE, 64'h0, 8);
			host.frame(op[i], 64'hffffffffff, nb[i]);
			chk("reject", 64'({busy, lock, bot, lvl}), 64'h0);
		end
		host.frame(OP_WRITE_DISABLE, 64'h0, 8);
	endtask

	task automatic t_prog();
		host.frame(OP_WRITE_ENABLE, 64'h0, 8);
		host.frame(OP_PAGE_PROG, 64'h0001005a, 40);
		chk("op_code", 64'({busy, opc}), 64'({1'b1, OP_PAGE_PROG}));
		host.frame(OP_SLEEP, 64'h0, 8);
		cyc(12);
		chk("sleep_busy", 64'(slp), 64'h0);
		host.frame(OP_STATUS_READ, 64'h0, 16);
		chk("busy_bit", 64'(host.rx[0]), 64'h1);
		idle();
		host.frame(OP_WRITE_ENABLE, 64'h0, 8);
		host.frame(OP_CHIP_ERASE_A, 64'h0, 8);
		chk("erase_code", 64'({busy, opc}), 64'({1'b1, OP_CHIP_ERASE_A}));
		chk("op_pulses", 64'(op_pulses), 64'h2);
		idle();
	endtask

	task automatic t_sleep();
		host.frame(OP_WRITE_ENABLE, 64'h0, 8);
		host.frame(OP_SLEEP, 64'h0, 8);
		chk("sleep_early", 64'(slp), 64'h0);
		cyc(10);
		chk("sleep", 64'(slp), 64'h1);
		host.frame(OP_WRITE_DISABLE, 64'h0, 8);
		chk("wel_asleep", 64'(wen), 64'h1);
		host.frame(OP_WAKE_ID, 64'h0, 48);
		chk("id_byte", 64'(host.rx[15:0]), 64'({ID1, ID1}));
		cyc(10);
		chk("awake", 64'(slp), 64'h0);
		host.frame(OP_WRITE_DISABLE, 64'h0, 8);
		chk("wel_awake", 64'(wen), 64'h0);
	endtask

	task automatic t_id4();
		host.frame(OP_ID4, 64'h0, 72);
		chk("id4", host.rx, {ID4, ID4});
		host.frame(OP_ID4, 64'h0, 20);
		chk("oe_off", 64'(oe), 64'h0);
	endtask

	// ======
	// main sequence
	initial begin
		clk   = 1'b0;
		rst_b = 1'b0;
		wp_b  = 1'b1;
		cyc(4);
		rst_b <= 1'b1;
		cyc(1);
		chk("reset", 64'({oe, busy, wen, lvl, bot, lock, slp, ops}), 64'h0);
		#500us;
		t_wel();
		status_write_time();
		t_reject();
		t_prog();
		t_sleep();
		t_id4();
		end_of_test();
	end

	// runs take about 630 us
	initial begin
		#1ms;
		error_cnt++;
		end_of_test();
	end
endmodule
